// file: hdl/xcvr_pwr_pkg.sv
// Package with constants for the transceiver power and enable controller.
// Functional notes
// RQ1 - Forced standby tri-states transmitters and main receivers.
// RQ2 - Thirty seconds without edges disables transmitters and charge pumps, not receivers.
// RQ3 - Any valid edge wakes supply and drivers.
// RQ4 - Force inputs override the inactivity logic.
// RQ5 - No force asserted: inactivity timer picks state.
// RQ6 - Shutdown stops both charge pumps, tri-states transmitters.
// RQ7 - Transmitters stay disabled 25 us after wake.
// RQ8 - Monitor receiver copy always driven, noninverting.
// RQ9 - Main receivers invert, tri-state in forced standby.
// RQ10 - Enabled transmitter drives inverse of its input.
// RQ11 - Signal-present high when any receiver line valid.
// RQ12 - Charge pumps run below 5.5 V, stop above.
// RQ13 - Host ties both force inputs for software control.
// RQ14 - Transmitter and force inputs hold last valid level.
// RQ15 - Force-on high gives normal; low lets timer govern.
// RQ16 - Only threshold-crossing edges restart the timer.
// RQ17 - Inactivity timer is a counter restarted by edges.
package xcvr_pwr_pkg;

    // Clock and timing.
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned IDLE_TIMEOUT_S = 30;
    localparam longint unsigned IDLE_CYCLES =
        longint'(IDLE_TIMEOUT_S) * 64'd1000000 * longint'(CLK_MHZ);
    localparam int unsigned WAKE_RECOVERY_US = 25;
    localparam int unsigned WAKE_CYCLES = WAKE_RECOVERY_US * CLK_MHZ;

    // Channel counts.
    localparam int unsigned NUM_TX = 5;
    localparam int unsigned NUM_RX = 3;

    // Register byte addresses.
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

    // Control register fields.
    localparam int unsigned CTRL_FORCE_ACT_BIT = 0;
    localparam int unsigned CTRL_FORCE_STBY_N_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h2;

    // Status register fields.
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_PRESENT_BIT = 2;
    localparam int unsigned ST_TXEN_BIT = 3;
    localparam int unsigned ST_PUMP_BIT = 4;

    // Interrupt event bits.
    localparam int unsigned EV_SLEEP_BIT = 0;
    localparam int unsigned EV_WAKE_BIT = 1;
    localparam int unsigned EV_PRESENT_BIT = 2;
    localparam int unsigned NUM_EV = 3;
    localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

    // Operating states, Gray coded in declaration order.
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_AUTO_OFF = 2'b01,
        ST_RECOVER = 2'b11,
        ST_FORCED_OFF = 2'b10
    } pwr_state_t;

    // AHB transfer type.
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

endpackage

// file: hdl/edge_sync.sv
// Two-stage synchroniser with edge detection for one pin.
`timescale 1ns/1ns
module edge_sync (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Asynchronous pin and its synchronised view.
    input wire logic pin_i,
    output logic level_o,
    output logic edge_o
);

    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // The first stage feeds only the second stage.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= pin_i;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // A change across the threshold-qualified level is an edge.
    assign level_o = sync_reg;
    assign edge_o = sync_reg ^ prev_reg; // see RQ16

endmodule // edge_sync

// file: hdl/xcvr_pwr_ctrl.sv
// Power, enable and inactivity controller for an RS-232 transceiver.
`timescale 1ns/1ns
module xcvr_pwr_ctrl #(
    parameter longint unsigned IDLE_COUNT = xcvr_pwr_pkg::IDLE_CYCLES,
    parameter int unsigned WAKE_COUNT = xcvr_pwr_pkg::WAKE_CYCLES
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Force pins and their driver enables (low means floating).
    input wire logic force_active_in_i,
    input wire logic force_active_drv_i,
    input wire logic force_standby_n_i,
    input wire logic force_standby_drv_i,
    // Transmitter logic inputs and their driver enables.
    input wire logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_in_i,
    input wire logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_drv_i,
    // Receiver line inputs: polarity and valid-level flag.
    input wire logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_line_i,
    input wire logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_valid_i,
    // Charge pump magnitude above 5.5 V comparators.
    input wire logic pump_pos_high_i,
    input wire logic pump_neg_high_i,
    // Transmitter outputs with enables.
    output logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_out_o,
    output logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_oe_o,
    // Receiver outputs with enables.
    output logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_out_o,
    output logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_oe_o,
    output logic monitor_rx_out_o,
    // Status and power outputs.
    output logic signal_present_o,
    output logic pump_pos_en_o,
    output logic pump_neg_en_o,
    output logic irq_o
);
    import xcvr_pwr_pkg::*;

    // Width of the inactivity counter; 33 bits reach 30 s at 250 MHz.
    localparam int unsigned IDLE_W = 33;

    // Refuse counts the counters cannot hold.
    if (IDLE_COUNT < 2 || IDLE_COUNT > 64'h1_ffff_ffff ||
        WAKE_COUNT < 1) begin : g_bad_timing
        $error("xcvr_pwr_ctrl: bad timing parameters");
    end

    // Synchronised pins and edges.
    localparam int unsigned NPIN = NUM_TX + NUM_RX * 2 + 4;
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_lvl;
    logic [NPIN-1:0] pin_edge;

    assign pin_raw = {pump_neg_high_i, pump_pos_high_i,
                      force_standby_drv_i, force_active_drv_i,
                      rx_valid_i, rx_line_i, tx_drv_i};

    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_sync
            edge_sync u_sync (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .pin_i(pin_raw[g]),
                .level_o(pin_lvl[g]),
                .edge_o(pin_edge[g])
            );
        end
    endgenerate

    // Held pins: the data path synchronises the pin, the holder keeps it.
    logic [NUM_TX+1:0] hold_raw;
    logic [NUM_TX+1:0] hold_lvl;
    logic [NUM_TX+1:0] hold_edge;
    assign hold_raw = {force_standby_n_i, force_active_in_i, tx_in_i};

    generate
        for (g = 0; g < NUM_TX + 2; g++) begin : g_hsync
            edge_sync u_hsync (
                .clk_i(clk_i),
                .rstn_i(rstn_i),
                .pin_i(hold_raw[g]),
                .level_o(hold_lvl[g]),
                .edge_o(hold_edge[g])
            );
        end
    endgenerate

    // Synchronised views of each pin group.
    wire [NUM_TX-1:0] tx_drv_s = pin_lvl[NUM_TX-1:0];
    wire [NUM_RX-1:0] rx_line_s = pin_lvl[NUM_TX +: NUM_RX];
    wire [NUM_RX-1:0] rx_valid_s = pin_lvl[NUM_TX+NUM_RX +: NUM_RX];
    wire [NUM_RX-1:0] rx_edge_s = pin_edge[NUM_TX +: NUM_RX];
    wire fa_drv_s = pin_lvl[NUM_TX+2*NUM_RX];
    wire fs_drv_s = pin_lvl[NUM_TX+2*NUM_RX+1];
    wire pos_high_s = pin_lvl[NUM_TX+2*NUM_RX+2];
    wire neg_high_s = pin_lvl[NUM_TX+2*NUM_RX+3];
    wire [NUM_TX+1:0] hold_drv = {fs_drv_s, fa_drv_s, tx_drv_s};

    // Bus-keeper: a driven input updates, a floating one keeps its level.
    logic [NUM_TX+1:0] keep_reg;
    logic [NUM_TX+1:0] keep_next;
    assign keep_next = (hold_drv & hold_lvl) | (~hold_drv & keep_reg);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            keep_reg <= {2'b10, {NUM_TX{1'b0}}};
        end else begin
            keep_reg <= keep_next; // see RQ14
        end
    end

    // Software control register; either the pin or software alone forces standby.
    logic [1:0] ctrl_reg;
    wire [NUM_TX-1:0] tx_level = keep_reg[NUM_TX-1:0];
    wire force_act = keep_reg[NUM_TX] | ctrl_reg[CTRL_FORCE_ACT_BIT];
    wire force_stby = ~keep_reg[NUM_TX+1] |
                      ~ctrl_reg[CTRL_FORCE_STBY_N_BIT];

    // Qualifying activity: threshold-crossing edges on driven tx inputs
    // or on receivers carrying a valid level.
    wire tx_act = |(hold_edge[NUM_TX-1:0] & tx_drv_s);
    wire rx_act = |(rx_edge_s & rx_valid_s);
    wire activity = tx_act | rx_act; // see RQ16

    // Inactivity counter, restarted by each qualifying edge.
    logic [IDLE_W-1:0] idle_cnt_reg;
    logic [IDLE_W-1:0] idle_cnt_next;
    wire idle_done = idle_cnt_reg == IDLE_W'(IDLE_COUNT - 1);
    assign idle_cnt_next = activity ? {IDLE_W{1'b0}} :
                           idle_done ? idle_cnt_reg :
                           idle_cnt_reg + IDLE_W'(1);

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idle_cnt_reg <= {IDLE_W{1'b0}};
        end else begin
            idle_cnt_reg <= idle_cnt_next; // see RQ17
        end
    end

    // Power state machine with forced inputs taking priority.
    pwr_state_t state_reg;
    pwr_state_t state_next;
    logic [31:0] wake_cnt_reg;
    wire wake_done = wake_cnt_reg == 32'(WAKE_COUNT - 1);

    always_comb begin
        state_next = state_reg;
        if (force_stby) begin
            state_next = ST_FORCED_OFF; // see RQ1, RQ4
        end else begin
            case (state_reg)
                ST_ACTIVE: begin
                    if (!force_act && idle_done) begin
                        state_next = ST_AUTO_OFF; // see RQ2, RQ5, RQ15
                    end
                end
                ST_AUTO_OFF: begin
                    if (activity || force_act) begin
                        state_next = ST_RECOVER; // see RQ3, RQ4
                    end
                end
                ST_RECOVER: begin
                    if (wake_done) begin
                        state_next = ST_ACTIVE; // see RQ7
                    end
                end
                ST_FORCED_OFF: begin
                    state_next = ST_RECOVER;
                end
                default: begin
                    state_next = ST_FORCED_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_FORCED_OFF;
            wake_cnt_reg <= 32'h0000_0000;
        end else begin
            state_reg <= state_next;
            wake_cnt_reg <= (state_reg == ST_RECOVER) ?
                            wake_cnt_reg + 32'h0000_0001 :
                            32'h0000_0000; // see RQ7
        end
    end

    // Supply and output enables derived from the state.
    wire supply_on = state_next != ST_AUTO_OFF &&
                     state_next != ST_FORCED_OFF; // see RQ6
    wire tx_en = state_next == ST_ACTIVE; // see RQ7
    wire rx_en = state_next != ST_FORCED_OFF; // see RQ9
    wire present = |rx_valid_s;

    // Registered pin outputs.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_out_o <= '0;
            tx_oe_o <= '0;
            rx_out_o <= '0;
            rx_oe_o <= '0;
            monitor_rx_out_o <= 1'b0;
            signal_present_o <= 1'b0;
            pump_pos_en_o <= 1'b0;
            pump_neg_en_o <= 1'b0;
        end else begin
            tx_out_o <= ~tx_level; // see RQ10
            tx_oe_o <= {NUM_TX{tx_en}}; // see RQ2, RQ6
            rx_out_o <= ~rx_line_s; // see RQ9
            rx_oe_o <= {NUM_RX{rx_en}}; // see RQ1
            monitor_rx_out_o <= rx_line_s[0]; // see RQ8
            signal_present_o <= present; // see RQ11
            pump_pos_en_o <= supply_on & ~pos_high_s; // see RQ12
            pump_neg_en_o <= supply_on & ~neg_high_s; // see RQ12
        end
    end

    // Interrupt events: sleep entry, wake, signal-present change.
    logic present_d_reg;
    logic [NUM_EV-1:0] irq_stat_reg;
    logic [NUM_EV-1:0] irq_mask_reg;
    logic [NUM_EV-1:0] ev;
    assign ev[EV_SLEEP_BIT] = state_reg != ST_AUTO_OFF &&
                              state_next == ST_AUTO_OFF;
    assign ev[EV_WAKE_BIT] = state_reg == ST_RECOVER &&
                             state_next == ST_ACTIVE;
    assign ev[EV_PRESENT_BIT] = present != present_d_reg;

    // AHB address phase capture.
    logic wr_pend_reg;
    logic [7:0] addr_reg;
    wire take = hsel_i & hready_i & htrans_i[1];
    wire wr_ctrl = wr_pend_reg && addr_reg == CTRL_OFS;
    wire wr_stat = wr_pend_reg && addr_reg == IRQ_STAT_OFS;
    wire wr_mask = wr_pend_reg && addr_reg == IRQ_MASK_OFS;

    // Read data for the next data phase.
    logic [31:0] rd_mux;
    wire [7:0] rd_addr = haddr_i[7:0];
    wire [4:0] status_word = {supply_on, tx_en, present, state_next};
    assign rd_mux = (rd_addr == CTRL_OFS) ? {30'h0, ctrl_reg} :
                    (rd_addr == STATUS_OFS) ? {27'h0, status_word} :
                    (rd_addr == IRQ_STAT_OFS) ? {29'h0, irq_stat_reg} :
                    (rd_addr == IRQ_MASK_OFS) ? {29'h0, irq_mask_reg} :
                    32'h0000_0000;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_pend_reg <= 1'b0;
            addr_reg <= 8'h00;
            hrdata_o <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= take & hwrite_i;
            addr_reg <= haddr_i[7:0];
            if (take && !hwrite_i) begin
                hrdata_o <= rd_mux;
            end
        end
    end

    // Writable registers; a hardware event wins over a clearing write.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl_reg <= CTRL_RESET;
            irq_mask_reg <= IRQ_MASK_RESET;
            irq_stat_reg <= '0;
            present_d_reg <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            present_d_reg <= present;
            if (wr_ctrl) begin
                ctrl_reg <= hwdata_i[1:0];
            end
            if (wr_mask) begin
                irq_mask_reg <= hwdata_i[NUM_EV-1:0];
            end
            irq_stat_reg <= (irq_stat_reg &
                             ~(wr_stat ? hwdata_i[NUM_EV-1:0] : '0)) | ev;
            irq_o <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // Zero wait states and an always-OKAY response.
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;

endmodule // xcvr_pwr_ctrl

// file: tb/pump_model.sv
// Behavioural charge pump that answers the controller's run enables.
`timescale 1ns/1ns
module pump_model (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Pump run enables from the controller.
    input wire logic pos_en_i,
    input wire logic neg_en_i,
    // Comparator outputs, high above the regulation level.
    output logic pos_high_o,
    output logic neg_high_o
);
    logic [3:0] pos_reg;
    logic [3:0] neg_reg;

    // The rail charges while its pump runs and sags while it is stopped.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pos_reg <= 4'h0;
            neg_reg <= 4'h0;
        end else begin
            pos_reg <= pos_en_i ? pos_reg + {3'h0, pos_reg != 4'hf}
                                : pos_reg - {3'h0, pos_reg != 4'h0};
            neg_reg <= neg_en_i ? neg_reg + {3'h0, neg_reg != 4'hf}
                                : neg_reg - {3'h0, neg_reg != 4'h0};
        end
    end

    // Comparators trip at mid scale, so the rail crosses them both ways.
    assign pos_high_o = pos_reg[3];
    assign neg_high_o = neg_reg[3];
endmodule // pump_model

// file: tb/xcvr_pwr_ctrl_props.sv
// Checker for the transceiver power controller ports.
`timescale 1ns/1ns
module xcvr_pwr_ctrl_props #(
    parameter longint unsigned IDLE_COUNT = 200,
    parameter int unsigned WAKE_COUNT = 10
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rstn_i,
    // Watched inputs.
    input wire logic force_standby_n_i,
    input wire logic force_standby_drv_i,
    input wire logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_in_i,
    input wire logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_drv_i,
    input wire logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_line_i,
    input wire logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_valid_i,
    input wire logic pump_pos_high_i,
    input wire logic pump_neg_high_i,
    // Watched outputs.
    input wire logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_out_o,
    input wire logic [xcvr_pwr_pkg::NUM_TX-1:0] tx_oe_o,
    input wire logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_out_o,
    input wire logic [xcvr_pwr_pkg::NUM_RX-1:0] rx_oe_o,
    input wire logic monitor_rx_out_o,
    input wire logic signal_present_o,
    input wire logic pump_pos_en_o,
    input wire logic pump_neg_en_o,
    input wire logic irq_o
);
    import xcvr_pwr_pkg::*;
    logic [3:0] age_reg;
    logic settled;

    // Counts edges since reset so pipeline fill is not judged.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            age_reg <= 4'h0;
        end else if (age_reg != 4'h8) begin
            age_reg <= age_reg + 4'h1;
        end
    end
    assign settled = age_reg == 4'h8;

    // Counts cycles with the transmitters off, saturating.
    logic [15:0] low_cnt_reg;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt_reg <= 16'h0000;
        end else if (tx_oe_o[0]) begin
            low_cnt_reg <= 16'h0000;
        end else if (low_cnt_reg != 16'hffff) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    standby_all_off_a: assert property (
        !rx_oe_o[0] |-> tx_oe_o == '0 && !pump_pos_en_o && !pump_neg_en_o)
        else $error("outputs active in forced standby");
    standby_pin_wins_a: assert property (
        (settled && force_standby_drv_i && !force_standby_n_i) [*5]
        |-> rx_oe_o == '0) else $error("standby pin ignored");
    tx_inverse_a: assert property (
        (settled && tx_drv_i == '1 && $stable(tx_in_i)) [*6]
        |-> tx_oe_o != '1 || tx_out_o == ~tx_in_i)
        else $error("transmitter not inverting");
    rx_inverse_a: assert property (
        (settled && $stable(rx_line_i)) [*5]
        |-> rx_oe_o != '1 || rx_out_o == ~rx_line_i)
        else $error("receiver not inverting");
    monitor_copy_a: assert property (
        (settled && $stable(rx_line_i[0])) [*5]
        |-> monitor_rx_out_o == rx_line_i[0]) else $error("monitor wrong");
    present_follow_a: assert property (
        (settled && $stable(rx_valid_i)) [*5]
        |-> signal_present_o == |rx_valid_i) else $error("present wrong");
    recover_hold_a: assert property (
        $rose(tx_oe_o[0]) |-> low_cnt_reg >= 16'(WAKE_COUNT))
        else $error("transmitters back too soon");
    pump_stop_a: assert property (
        (settled && pump_pos_high_i) [*5] |-> !pump_pos_en_o)
        else $error("pump runs above level");
    pump_run_a: assert property (
        (settled && !pump_neg_high_i && tx_oe_o[0]) [*5] |-> pump_neg_en_o)
        else $error("pump idle below level");

    // Main scenarios reached.
    cover property ($fell(tx_oe_o[0]) && rx_oe_o[0]);
    cover property ($fell(rx_oe_o[0]));
    cover property ($rose(irq_o));
endmodule // xcvr_pwr_ctrl_props

bind xcvr_pwr_ctrl xcvr_pwr_ctrl_props #(
    .IDLE_COUNT(IDLE_COUNT), .WAKE_COUNT(WAKE_COUNT)) props_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .force_standby_n_i(force_standby_n_i),
    .force_standby_drv_i(force_standby_drv_i), .tx_in_i(tx_in_i),
    .tx_drv_i(tx_drv_i), .rx_line_i(rx_line_i), .rx_valid_i(rx_valid_i),
    .pump_pos_high_i(pump_pos_high_i), .pump_neg_high_i(pump_neg_high_i),
    .tx_out_o(tx_out_o), .tx_oe_o(tx_oe_o), .rx_out_o(rx_out_o),
    .rx_oe_o(rx_oe_o), .monitor_rx_out_o(monitor_rx_out_o),
    .signal_present_o(signal_present_o), .pump_pos_en_o(pump_pos_en_o),
    .pump_neg_en_o(pump_neg_en_o), .irq_o(irq_o));

// file: tb/test_xcvr_pwr_ctrl.sv
// Self-checking testbench for the transceiver power controller.
`timescale 1ns/1ns
module test_xcvr_pwr_ctrl;
    import xcvr_pwr_pkg::*;
    logic clk_i = 0, rstn_i = 0, hsel_i = 0, hwrite_i = 0;
    logic [31:0] haddr_i = 0, hwdata_i = 0, hrdata_o, rd;
    logic [1:0] htrans_i = 0;
    logic [2:0] hsize_i = 3'h2, rx_line_i = 3'h5, rx_valid_i = 3'h1;
    logic force_active_in_i = 0, force_active_drv_i = 1;
    logic force_standby_n_i = 1, force_standby_drv_i = 1;
    logic [4:0] tx_in_i = 5'h0a, tx_drv_i = 5'h1f, tx_out_o, tx_oe_o;
    logic [2:0] rx_out_o, rx_oe_o;
    logic hreadyout_o, hresp_o, monitor_rx_out_o, signal_present_o, irq_o;
    logic pump_pos_high_i, pump_neg_high_i, pump_pos_en_o, pump_neg_en_o;
    int mismatches = 0;
    int samples_checked = 0;

    // Clock of 4 ns period.
    always #2 clk_i = ~clk_i;

    xcvr_pwr_ctrl #(.IDLE_COUNT(200), .WAKE_COUNT(10)) xcvr_pwr_ctrl_i (
        .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
        .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
        .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .force_active_in_i(force_active_in_i),
        .force_active_drv_i(force_active_drv_i),
        .force_standby_n_i(force_standby_n_i),
        .force_standby_drv_i(force_standby_drv_i), .tx_in_i(tx_in_i),
        .tx_drv_i(tx_drv_i), .rx_line_i(rx_line_i), .rx_valid_i(rx_valid_i),
        .pump_pos_high_i(pump_pos_high_i), .pump_neg_high_i(pump_neg_high_i),
        .tx_out_o(tx_out_o), .tx_oe_o(tx_oe_o), .rx_out_o(rx_out_o),
        .rx_oe_o(rx_oe_o), .monitor_rx_out_o(monitor_rx_out_o),
        .signal_present_o(signal_present_o), .pump_pos_en_o(pump_pos_en_o),
        .pump_neg_en_o(pump_neg_en_o), .irq_o(irq_o));

    pump_model pump_model_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .pos_en_i(pump_pos_en_o), .neg_en_i(pump_neg_en_o),
        .pos_high_o(pump_pos_high_i), .neg_high_o(pump_neg_high_i));

    // Prints the counts and the verdict, then stops.
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Waits for hready under a bound; running out ends the run.
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 20);
        if (n == 20) begin
            mismatches++;
            wrap_up();
        end
    endtask

    // One single word transfer; read data lands in rd.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= HTRANS_NONSEQ;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        wait_ready();
        hsel_i <= 1'b0;
        htrans_i <= 2'b00;
        hwdata_i <= d;
        wait_ready();
        rd = hrdata_o;
    endtask

    task automatic t_power_up();
        cycles(3);
        check(tx_oe_o, 0);
        cycles(20);
        check(tx_oe_o, 5'h1f);
        check(tx_out_o, 5'h15);
        check(rx_out_o, 3'h2);
        check(monitor_rx_out_o, 1);
        check(signal_present_o, 1);
        check(hresp_o, 0);
        bus(0, CTRL_OFS, 0);
        check(rd, 32'h2);
        bus(0, IRQ_MASK_OFS, 0);
        check(rd, 0);
        bus(0, 8'h10, 0);
        check(rd, 0);
        bus(0, STATUS_OFS, 0);
        check(rd[3:0], 4'hc);
        rx_valid_i <= 3'h0;
        cycles(6);
        check(signal_present_o, 0);
        rx_valid_i <= 3'h1;
        $display("power up test done");
    endtask

    task automatic t_forced();
        force_standby_n_i <= 1'b0;
        cycles(6);
        check(rx_oe_o, 0);
        check(tx_oe_o, 0);
        check({pump_pos_en_o, pump_neg_en_o}, 0);
        rx_line_i <= 3'h4;
        cycles(6);
        check(monitor_rx_out_o, 0);
        force_standby_drv_i <= 1'b0;
        force_standby_n_i <= 1'b1;
        cycles(6);
        check(rx_oe_o, 0);
        force_standby_drv_i <= 1'b1;
        cycles(5);
        check(tx_oe_o, 0);
        cycles(20);
        check(tx_oe_o, 5'h1f);
        bus(1, CTRL_OFS, 0);
        cycles(6);
        check(rx_oe_o, 0);
        bus(0, STATUS_OFS, 0);
        check(rd[1:0], 2'h2);
        bus(1, CTRL_OFS, 2);
        cycles(25);
        check(tx_oe_o, 5'h1f);
        $display("forced standby test done");
    endtask

    task automatic t_idle();
        bus(1, IRQ_MASK_OFS, 1);
        cycles(230);
        check(tx_oe_o, 0);
        check(rx_oe_o, 3'h7);
        check({pump_pos_en_o, pump_neg_en_o}, 0);
        check(irq_o, 1);
        bus(0, STATUS_OFS, 0);
        check(rd[1:0], 2'h1);
        bus(1, IRQ_STAT_OFS, 1);
        cycles(2);
        check(irq_o, 0);
        tx_drv_i <= 5'h1d;
        tx_in_i <= 5'h08;
        rx_line_i <= 3'h6;
        cycles(20);
        check(tx_oe_o, 0);
        tx_in_i <= 5'h09;
        cycles(4);
        check(tx_oe_o, 0);
        cycles(25);
        check(tx_oe_o, 5'h1f);
        check(tx_out_o, 5'h14);
        tx_drv_i <= 5'h1f;
        tx_in_i <= 5'h0b;
        $display("inactivity test done");
    endtask

    task automatic t_force_on();
        force_active_in_i <= 1'b1;
        cycles(230);
        check(tx_oe_o, 5'h1f);
        force_active_in_i <= 1'b0;
        cycles(230);
        check(tx_oe_o, 0);
        bus(1, CTRL_OFS, 3);
        cycles(20);
        check(tx_oe_o, 5'h1f);
        bus(1, CTRL_OFS, 2);
        cycles(20);
        check(tx_oe_o, 0);
        $display("force on test done");
    endtask

    // Main sequence.
    initial begin
        cycles(3);
        rstn_i <= 1'b1;
        t_power_up();
        t_forced();
        t_idle();
        t_force_on();
        wrap_up();
    end
endmodule // test_xcvr_pwr_ctrl
